/* File: design/rcb_pkg.sv */
`default_nettype none
package rcb_pkg;
  // Channel register offsets
  localparam logic [7:0] RCB_OFS_SOFT_RESET = 8'h00;
  localparam logic [7:0] RCB_OFS_LOSS_FLAGS = 8'h01;
  localparam logic [7:0] RCB_OFS_LOCK_STATUS = 8'h02;
  localparam logic [7:0] RCB_OFS_MANUAL_BOOST = 8'h03;
  localparam logic [7:0] RCB_OFS_CAP_START0 = 8'h08;
  localparam logic [7:0] RCB_OFS_OVERRIDE = 8'h09;
  localparam logic [7:0] RCB_OFS_DEEMPH = 8'h15;
  localparam logic [7:0] RCB_OFS_DRIVER_CFG = 8'h2d;
  localparam logic [7:0] RCB_OFS_LOW_RATE_EQ = 8'h3a;
  localparam logic [7:0] RCB_OFS_TABLE_BASE = 8'h40;
  localparam logic [7:0] RCB_OFS_TABLE_LAST = 8'h4f;
  localparam logic [7:0] RCB_OFS_BOOST_READBACK = 8'h52;
  localparam logic [7:0] RCB_OFS_TARGET_SELECT = 8'hff;

  // Field positions
  localparam int RCB_BIT_SOFT_RESET = 2;
  localparam int RCB_BIT_LOCK_LOSS = 4;
  localparam int RCB_BIT_SIGNAL_LOSS = 0;
  localparam int RCB_BIT_FAIL_CHECK = 5;
  localparam int RCB_BIT_LOCK = 4;
  localparam int RCB_BIT_CDR_LOCK = 3;
  localparam int RCB_BIT_MANUAL_BOOST_EN = 3;
  localparam int RCB_BIT_DEEMPH_RANGE = 6;
  localparam int RCB_BIT_SEL_CHANNEL = 0;
  localparam int RCB_BIT_SEL_CHAN_REGS = 2;
  localparam logic [7:0] RCB_CAP_START_MASK = 8'h1f;

  // Reset values
  localparam logic [7:0] RCB_RST_BYTE = 8'h00;
  localparam logic [7:0] RCB_RST_DEEMPH = 8'h00;
  localparam logic [7:0] RCB_RST_LOW_RATE_EQ = 8'h00;
  localparam logic [7:0] RCB_RST_TARGET_SELECT = 8'h00;

  // VCO range codes per channel
  localparam logic [1:0] RCB_VCO_DIV4 = 2'h2;
  localparam logic [1:0] RCB_VCO_DIV8 = 2'h3;

  // Default adaptation boost candidates, index 0 to 15
  localparam logic [7:0] RCB_TABLE_DEF [16] = '{8'h00, 8'h40, 8'h80, 8'h50, 8'hc0, 8'h90, 8'h54, 8'ha0,
                                                8'hb0, 8'h95, 8'h69, 8'hd5, 8'h99, 8'ha5, 8'he6, 8'hf9};

  // De-emphasis depth in tenths of a dB, by level code
  localparam logic [6:0] RCB_DEEMPH_FINE [8] = '{7'h00, 7'h09, 7'h14, 7'h1c, 7'h21, 7'h27, 7'h2d, 7'h38};
  localparam logic [6:0] RCB_DEEMPH_COARSE [8] = '{7'h00, 7'h0f, 7'h23, 7'h32, 7'h3c, 7'h4b, 7'h5a, 7'h78};
endpackage : rcb_pkg
`default_nettype wire

/* File: design/rcb_channel_bank.sv */
// Behaviour
// R1: De-emphasis comes from level code bits 2:0 and range bit 6 of driver_deemphasis_ctrl.
// R2: Fifteen settings; code zero range clear is 0 dB, deepest is -12 dB.
// R3: Range set, codes 1..7 give -0.9 through -5.6 dB.
// R4: Range clear, codes 1..7 give -1.5 through -12.0 dB.
// R5: In divide-by-4 or divide-by-8 range, low_rate_equalizer_value drives CTLE directly, unadapted.
// R6: Host should raise the low-rate CTLE value for long lossy channels.
// R7: Each channel keeps its own full register set.
// R8: Register channel_target_select selects channel or shared target until rewritten.
// R9: Only one channel_target_select register exists, reachable under any selection.
// R10: Writing one to channel_soft_reset bit 2 resets the selected channel; bit self-clears.
// R11: loss_event_flags read-only; bit 4 lock loss, bit 0 signal loss; zero at reset.
// R12: recovery_lock_status read-only status: bit 5 fail check, bit 4 lock, bit 3 CDR lock.
// R13: manual_equalizer_boost holds four boost stages, applied only while 0x2d bit 3 high.
// R14: Boost actually driven to the equalizer reads back at 0x52.
// R15: cap_start_group_zero bits 4:0 hold cap-DAC start group 0, default zero; 7:5 reserved.
// R16: Host reaches channel registers through management interface transactions.
// R17: Channel soft reset also restores the boost candidate table defaults.
// R18: Reset bit reads zero afterwards; writing zero does nothing.
`timescale 1ns/1ps
`default_nettype none
module rcb_channel_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port from the management interface
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Analog status, asynchronous, one bit per channel
  input wire logic [1:0] cdr_lock_in,
  input wire logic [1:0] lock_in,
  input wire logic [1:0] lock_fail_in,
  input wire logic [1:0] sig_detect_in,
  // Rate and adaptation inputs, two bits or one byte per channel
  input wire logic [3:0] vco_div_range,
  input wire logic [15:0] adapt_boost_in,
  // Per-channel controls to the analog side
  output logic [15:0] ctle_boost_out,
  output logic [5:0] deemph_level_out,
  output logic [1:0] deemph_range_out,
  output logic [13:0] deemph_tenths_db_out,
  output logic [9:0] cap_start_out,
  output logic [15:0] override_out,
  output logic [15:0] driver_cfg_out
);

  // Register state
  logic [7:0] sel_reg, sel_next;
  logic [7:0] flags_reg [2], flags_next [2];
  logic [7:0] boost_reg [2], boost_next [2];
  logic [7:0] cap_reg [2], cap_next [2];
  logic [7:0] ovr_reg [2], ovr_next [2];
  logic [7:0] dem_reg [2], dem_next [2];
  logic [7:0] drv_reg [2], drv_next [2];
  logic [7:0] low_reg [2], low_next [2];
  logic [7:0] tab_reg [2][16], tab_next [2][16];
  logic [7:0] ctle_reg [2], ctle_next [2];
  logic [6:0] tenths_reg [2], tenths_next [2];
  logic [7:0] rdata_next;
  logic rvalid_next;
  // Synchroniser state: bit order sigdet, cdr lock, lock, fail per channel
  logic [7:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;
  logic [7:0] async_in;
  logic chan_sel;
  logic chan_tgt;
  logic soft_rst;

  assign async_in = {lock_fail_in, lock_in, cdr_lock_in, sig_detect_in};
  assign chan_sel = sel_reg[rcb_pkg::RCB_BIT_SEL_CHANNEL];
  assign chan_tgt = sel_reg[rcb_pkg::RCB_BIT_SEL_CHAN_REGS];
  assign soft_rst = reg_wr && chan_tgt && reg_addr == rcb_pkg::RCB_OFS_SOFT_RESET &&
                    reg_wdata[rcb_pkg::RCB_BIT_SOFT_RESET]; // [R10] [R18]

  // Status filter: a change counts once stages two and three agree
  always_comb begin
    filt_next = filt_reg;
    for (int b = 0; b < 8; b++) begin
      if (sync2_reg[b] == sync3_reg[b]) filt_next[b] = sync3_reg[b];
    end
  end

  // Next register values for both channels and the select register
  always_comb begin
    sel_next = sel_reg;
    if (reg_wr && reg_addr == rcb_pkg::RCB_OFS_TARGET_SELECT) sel_next = reg_wdata; // [R8] [R9]
    for (int c = 0; c < 2; c++) begin
      flags_next[c] = flags_reg[c];
      boost_next[c] = boost_reg[c];
      cap_next[c] = cap_reg[c];
      ovr_next[c] = ovr_reg[c];
      dem_next[c] = dem_reg[c];
      drv_next[c] = drv_reg[c];
      low_next[c] = low_reg[c];
      for (int i = 0; i < 16; i++) tab_next[c][i] = tab_reg[c][i];
      // Reading the flags clears them
      if (reg_rd && chan_tgt && chan_sel == c[0] && reg_addr == rcb_pkg::RCB_OFS_LOSS_FLAGS)
        flags_next[c] = rcb_pkg::RCB_RST_BYTE;
      // Writes land only in the selected channel's copy
      if (reg_wr && chan_tgt && chan_sel == c[0]) begin // [R7] [R16]
        case (reg_addr)
          rcb_pkg::RCB_OFS_MANUAL_BOOST: boost_next[c] = reg_wdata; // [R13]
          rcb_pkg::RCB_OFS_CAP_START0: cap_next[c] = reg_wdata & rcb_pkg::RCB_CAP_START_MASK; // [R15]
          rcb_pkg::RCB_OFS_OVERRIDE: ovr_next[c] = reg_wdata;
          rcb_pkg::RCB_OFS_DEEMPH: dem_next[c] = reg_wdata; // [R1]
          rcb_pkg::RCB_OFS_DRIVER_CFG: drv_next[c] = reg_wdata;
          rcb_pkg::RCB_OFS_LOW_RATE_EQ: low_next[c] = reg_wdata; // [R6]
          default: begin
            if (reg_addr >= rcb_pkg::RCB_OFS_TABLE_BASE && reg_addr <= rcb_pkg::RCB_OFS_TABLE_LAST)
              tab_next[c][reg_addr[3:0]] = reg_wdata;
          end
        endcase
      end
      // Loss events set the sticky flags; set wins over the read clear, soft reset wins over set
      if (filt_reg[2 + c] && !filt_next[2 + c]) flags_next[c][rcb_pkg::RCB_BIT_LOCK_LOSS] = 1'b1; // [R11]
      if (filt_reg[c] && !filt_next[c]) flags_next[c][rcb_pkg::RCB_BIT_SIGNAL_LOSS] = 1'b1; // [R11]
      // Soft reset returns the whole channel copy to defaults
      if (soft_rst && chan_sel == c[0]) begin // [R10]
        flags_next[c] = rcb_pkg::RCB_RST_BYTE;
        boost_next[c] = rcb_pkg::RCB_RST_BYTE;
        cap_next[c] = rcb_pkg::RCB_RST_BYTE;
        ovr_next[c] = rcb_pkg::RCB_RST_BYTE;
        dem_next[c] = rcb_pkg::RCB_RST_DEEMPH;
        drv_next[c] = rcb_pkg::RCB_RST_BYTE;
        low_next[c] = rcb_pkg::RCB_RST_LOW_RATE_EQ;
        for (int i = 0; i < 16; i++) tab_next[c][i] = rcb_pkg::RCB_TABLE_DEF[i]; // [R17]
      end
      // Boost source: manual stages, then low-rate fixed value, then adaptation
      if (drv_reg[c][rcb_pkg::RCB_BIT_MANUAL_BOOST_EN]) ctle_next[c] = boost_reg[c]; // [R13]
      else if (vco_div_range[2*c +: 2] == rcb_pkg::RCB_VCO_DIV4 ||
               vco_div_range[2*c +: 2] == rcb_pkg::RCB_VCO_DIV8) ctle_next[c] = low_reg[c]; // [R5]
      else ctle_next[c] = adapt_boost_in[8*c +: 8];
      // De-emphasis decode, range bit picks the fine table
      if (dem_reg[c][rcb_pkg::RCB_BIT_DEEMPH_RANGE])
        tenths_next[c] = rcb_pkg::RCB_DEEMPH_FINE[dem_reg[c][2:0]]; // [R2] [R3]
      else
        tenths_next[c] = rcb_pkg::RCB_DEEMPH_COARSE[dem_reg[c][2:0]]; // [R2] [R4]
    end
  end

  // Read port answer for the selected target
  always_comb begin
    logic [7:0] st;
    st = 8'h00;
    // Status bits of the selected channel
    st[rcb_pkg::RCB_BIT_FAIL_CHECK] = filt_reg[6 + chan_sel];
    st[rcb_pkg::RCB_BIT_LOCK] = filt_reg[4 + chan_sel];
    st[rcb_pkg::RCB_BIT_CDR_LOCK] = filt_reg[2 + chan_sel]; // [R12]
    rvalid_next = reg_rd;
    rdata_next = 8'h00;
    if (reg_rd && reg_addr == rcb_pkg::RCB_OFS_TARGET_SELECT) rdata_next = sel_reg; // [R9]
    else if (reg_rd && chan_tgt) begin
      case (reg_addr)
        rcb_pkg::RCB_OFS_SOFT_RESET: rdata_next = 8'h00; // [R18]
        rcb_pkg::RCB_OFS_LOSS_FLAGS: rdata_next = flags_reg[chan_sel]; // [R11]
        rcb_pkg::RCB_OFS_LOCK_STATUS: rdata_next = st; // [R12]
        rcb_pkg::RCB_OFS_MANUAL_BOOST: rdata_next = boost_reg[chan_sel];
        rcb_pkg::RCB_OFS_CAP_START0: rdata_next = cap_reg[chan_sel];
        rcb_pkg::RCB_OFS_OVERRIDE: rdata_next = ovr_reg[chan_sel];
        rcb_pkg::RCB_OFS_DEEMPH: rdata_next = dem_reg[chan_sel];
        rcb_pkg::RCB_OFS_DRIVER_CFG: rdata_next = drv_reg[chan_sel];
        rcb_pkg::RCB_OFS_LOW_RATE_EQ: rdata_next = low_reg[chan_sel];
        rcb_pkg::RCB_OFS_BOOST_READBACK: rdata_next = ctle_reg[chan_sel]; // [R14]
        default: begin
          if (reg_addr >= rcb_pkg::RCB_OFS_TABLE_BASE && reg_addr <= rcb_pkg::RCB_OFS_TABLE_LAST)
            rdata_next = tab_reg[chan_sel][reg_addr[3:0]];
        end
      endcase
    end
  end

  // Register everything
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sel_reg <= rcb_pkg::RCB_RST_TARGET_SELECT;
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
      filt_reg <= 8'h00;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        flags_reg[c] <= rcb_pkg::RCB_RST_BYTE;
        boost_reg[c] <= rcb_pkg::RCB_RST_BYTE;
        cap_reg[c] <= rcb_pkg::RCB_RST_BYTE;
        ovr_reg[c] <= rcb_pkg::RCB_RST_BYTE;
        dem_reg[c] <= rcb_pkg::RCB_RST_DEEMPH;
        drv_reg[c] <= rcb_pkg::RCB_RST_BYTE;
        low_reg[c] <= rcb_pkg::RCB_RST_LOW_RATE_EQ;
        ctle_reg[c] <= rcb_pkg::RCB_RST_BYTE;
        tenths_reg[c] <= 7'h00;
        for (int i = 0; i < 16; i++) tab_reg[c][i] <= rcb_pkg::RCB_TABLE_DEF[i];
      end
    end else begin
      sel_reg <= sel_next;
      // Three-stage synchroniser for the status pins
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
      reg_rdata <= rdata_next;
      reg_rvalid <= rvalid_next;
      // Both channel copies
      for (int c = 0; c < 2; c++) begin
        flags_reg[c] <= flags_next[c];
        boost_reg[c] <= boost_next[c];
        cap_reg[c] <= cap_next[c];
        ovr_reg[c] <= ovr_next[c];
        dem_reg[c] <= dem_next[c];
        drv_reg[c] <= drv_next[c];
        low_reg[c] <= low_next[c];
        ctle_reg[c] <= ctle_next[c];
        tenths_reg[c] <= tenths_next[c];
        for (int i = 0; i < 16; i++) tab_reg[c][i] <= tab_next[c][i];
      end
    end
  end

  // Outputs to the analog side
  assign ctle_boost_out = {ctle_reg[1], ctle_reg[0]};
  assign deemph_level_out = {dem_reg[1][2:0], dem_reg[0][2:0]};
  assign deemph_range_out = {dem_reg[1][rcb_pkg::RCB_BIT_DEEMPH_RANGE], dem_reg[0][rcb_pkg::RCB_BIT_DEEMPH_RANGE]};
  assign deemph_tenths_db_out = {tenths_reg[1], tenths_reg[0]};
  assign cap_start_out = {cap_reg[1][4:0], cap_reg[0][4:0]};
  assign override_out = {ovr_reg[1], ovr_reg[0]};
  assign driver_cfg_out = {drv_reg[1], drv_reg[0]};

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Request shapes used by the checks
  sequence s_shared_write;
    reg_wr && !chan_tgt;
  endsequence
  sequence s_chan1_write;
    reg_wr && chan_tgt && chan_sel;
  endsequence
  sequence s_reset_write;
    soft_rst;
  endsequence
  sequence s_read_reset_bit;
    reg_rd && chan_tgt && reg_addr == rcb_pkg::RCB_OFS_SOFT_RESET;
  endsequence
  sequence s_boost_read;
    reg_rd && chan_tgt && reg_addr == rcb_pkg::RCB_OFS_BOOST_READBACK;
  endsequence

  // Select register and target
  select_persists_a: assert property (!(reg_wr && reg_addr == rcb_pkg::RCB_OFS_TARGET_SELECT) |=> // [R8]
      sel_reg == $past(sel_reg))
    else $error("select changed without a write");
  select_reachable_a: assert property (reg_rd && reg_addr == rcb_pkg::RCB_OFS_TARGET_SELECT |=> // [R9]
      reg_rdata == $past(sel_reg))
    else $error("select register not readable");
  shared_write_ignored_a: assert property (s_shared_write |=> // [R8]
      boost_reg[0] == $past(boost_reg[0]) && dem_reg[0] == $past(dem_reg[0]))
    else $error("write landed while shared target selected");
  shared_read_zero_a: assert property (reg_rd && !chan_tgt && // [R8]
      reg_addr != rcb_pkg::RCB_OFS_TARGET_SELECT |=> reg_rdata == 8'h00)
    else $error("shared target read returned channel data");
  other_copy_kept_a: assert property (s_chan1_write |=> // [R7]
      boost_reg[0] == $past(boost_reg[0]) && cap_reg[0] == $past(cap_reg[0]))
    else $error("write to channel one changed channel zero");

  // Soft reset, reset bit and cap start
  reset_restores_bank_a: assert property (s_reset_write |=> // [R10] [R17]
      boost_reg[chan_sel] == rcb_pkg::RCB_RST_BYTE && low_reg[chan_sel] == rcb_pkg::RCB_RST_LOW_RATE_EQ
      && tab_reg[chan_sel][15] == rcb_pkg::RCB_TABLE_DEF[15] && flags_reg[chan_sel] == rcb_pkg::RCB_RST_BYTE)
    else $error("channel reset left stale contents");
  reset_bit_zero_a: assert property (s_read_reset_bit |=> reg_rvalid && reg_rdata == 8'h00) // [R18]
    else $error("reset bit read back nonzero");
  reset_zero_write_a: assert property (reg_wr && chan_tgt && reg_addr == rcb_pkg::RCB_OFS_SOFT_RESET && // [R18]
      !reg_wdata[rcb_pkg::RCB_BIT_SOFT_RESET] |=> boost_reg[chan_sel] == $past(boost_reg[chan_sel]))
    else $error("writing zero to the reset bit changed the channel");
  cap_mask_a: assert property (reg_wr && chan_tgt && reg_addr == rcb_pkg::RCB_OFS_CAP_START0 |=> // [R15]
      cap_reg[chan_sel] == ($past(reg_wdata) & rcb_pkg::RCB_CAP_START_MASK))
    else $error("cap start write not masked");
  cap_reserved_a: assert property (cap_reg[1][7:5] == 3'h0) // [R15]
    else $error("cap start reserved bits set");

  // Equalizer boost source
  low_rate_fixed_a: assert property (!drv_reg[0][rcb_pkg::RCB_BIT_MANUAL_BOOST_EN] && vco_div_range[1] |=> // [R5]
      ctle_reg[0] == $past(low_reg[0]))
    else $error("low-rate boost not taken from register");
  manual_boost_a: assert property (drv_reg[0][3] |=> ctle_reg[0] == $past(boost_reg[0])) // [R13]
    else $error("manual boost not applied");
  readback_boost_a: assert property (s_boost_read |=> reg_rdata == $past(ctle_reg[chan_sel])) // [R14]
    else $error("boost readback mismatch");

  // De-emphasis decode
  deemph_zero_a: assert property (!dem_reg[0][6] && dem_reg[0][2:0] == 3'h0 |=> tenths_reg[0] == 7'h00) // [R2]
    else $error("code zero is not 0 dB");
  deemph_depth_a: assert property (dem_reg[0][6] == 1'b0 && dem_reg[0][2:0] == 3'h7 |=> // [R4]
      tenths_reg[0] == 7'h78)
    else $error("deepest setting is not twelve dB");
  deemph_fine_a: assert property (dem_reg[0][6] && dem_reg[0][2:0] == 3'h1 |=> tenths_reg[0] == 7'h09) // [R3]
    else $error("fine range code one wrong");

  // Status and loss flags
  loss_flag_a: assert property (filt_reg[2] && !filt_next[2] && !(soft_rst && !chan_sel) |=> // [R11]
      flags_reg[0][rcb_pkg::RCB_BIT_LOCK_LOSS])
    else $error("lock loss not flagged");
  signal_loss_flag_a: assert property (filt_reg[0] && !filt_next[0] && !(soft_rst && !chan_sel) |=> // [R11]
      flags_reg[0][rcb_pkg::RCB_BIT_SIGNAL_LOSS])
    else $error("signal loss not flagged");
  status_bits_a: assert property (reg_rd && chan_tgt && reg_addr == rcb_pkg::RCB_OFS_LOCK_STATUS |=> // [R12]
      reg_rdata[2:0] == 3'h0 && reg_rdata[7:6] == 2'h0)
    else $error("status reserved bits set");

endmodule : rcb_channel_bank
`default_nettype wire

/* File: verif/rcb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rcb_host_model (
  // Clock
  input wire logic ref_clk,
  // Requests toward the bank
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  // Answers from the bank
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Quiet port from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write pulse; address and data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // One-cycle read pulse; answer taken in the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : rcb_host_model
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, srst, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] cdr_lock_in, lock_in, lock_fail_in, sig_detect_in, deemph_range_out;
  logic [3:0] vco_div_range;
  logic [15:0] adapt_boost_in, ctle_boost_out, override_out, driver_cfg_out;
  logic [5:0] deemph_level_out;
  logic [13:0] deemph_tenths_db_out;
  logic [9:0] cap_start_out;
  int fail_count = 0;
  int n_compared = 0;
  // Expected depth in tenths of a dB, by level code
  logic [6:0] fine_t [8] = '{7'h00, 7'h09, 7'h14, 7'h1c, 7'h21, 7'h27, 7'h2d, 7'h38};
  logic [6:0] coarse_t [8] = '{7'h00, 7'h0f, 7'h23, 7'h32, 7'h3c, 7'h4b, 7'h5a, 7'h78};
  logic [7:0] rst_ofs [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h15, 8'h3a};

  rcb_channel_bank u_dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cdr_lock_in(cdr_lock_in), .lock_in(lock_in), .lock_fail_in(lock_fail_in),
    .sig_detect_in(sig_detect_in), .vco_div_range(vco_div_range), .adapt_boost_in(adapt_boost_in),
    .ctle_boost_out(ctle_boost_out), .deemph_level_out(deemph_level_out),
    .deemph_range_out(deemph_range_out), .deemph_tenths_db_out(deemph_tenths_db_out),
    .cap_start_out(cap_start_out), .override_out(override_out), .driver_cfg_out(driver_cfg_out));
  rcb_host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // Clock generator
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk

  // Read one register and compare data and valid
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    chk("reg_rvalid", 16'h0001, {15'h0000, ok});
    chk($sformatf("reg_%h", a), {8'h00, exp}, {8'h00, d});
  endtask : rchk

  task automatic tdone(input string nm);
    $display("Test %s done", nm);
  endtask : tdone

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // Watchdog, far beyond the fewer than two hundred cycles of the tests
  initial begin
    #(20000 * 40);
    fail_count++;
    summarize();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    {cdr_lock_in, lock_in, lock_fail_in, sig_detect_in} = 8'h00;
    vco_div_range = 4'h0;
    adapt_boost_in = 16'hc3a1;
    repeat (5) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    // Shared target refuses channel writes; select reads back
    rchk(8'hff, 8'h00);
    u_host.wr(8'h03, 8'h5a);
    rchk(8'h03, 8'h00);
    u_host.wr(8'hff, 8'h04);
    rchk(8'hff, 8'h04);
    u_host.wr(8'h01, 8'hff);
    u_host.wr(8'h02, 8'hff);
    foreach (rst_ofs[i]) rchk(rst_ofs[i], 8'h00);
    tdone("reset_values");
    // Every de-emphasis code in both ranges
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        u_host.wr(8'h15, {1'b0, r[0], 3'h0, c[2:0]});
        @(posedge ref_clk);
        #1;
        chk("deemph_db", {9'h000, r[0] ? fine_t[c] : coarse_t[c]}, {9'h000, deemph_tenths_db_out[6:0]});
        chk("deemph_code", {12'h000, r[0], c[2:0]}, {12'h000, deemph_range_out[0], deemph_level_out[2:0]});
        chk("deemph_ch1", 16'h0000, {9'h000, deemph_tenths_db_out[13:7]});
      end
    end
    tdone("deemphasis");
    // Boost source: adaptive, low-rate fixed value, manual stages
    u_host.wr(8'h3a, 8'h77);
    for (int v = 0; v < 4; v++) begin
      vco_div_range = {2'h0, v[1:0]};
      repeat (2) @(posedge ref_clk);
      #1;
      rchk(8'h52, v > 1 ? 8'h77 : 8'ha1);
    end
    u_host.wr(8'h03, 8'h55);
    rchk(8'h52, 8'h77);
    u_host.wr(8'h2d, 8'h08);
    @(posedge ref_clk);
    #1;
    rchk(8'h52, 8'h55);
    chk("ctle_boost", 16'hc355, ctle_boost_out);
    chk("driver_cfg", 16'h0008, driver_cfg_out);
    tdone("boost_source");
    // Separate copies per channel; reserved bits of the cap start
    u_host.wr(8'h08, 8'hff);
    rchk(8'h08, 8'h1f);
    u_host.wr(8'hff, 8'h05);
    rchk(8'h08, 8'h00);
    rchk(8'hff, 8'h05);
    u_host.wr(8'h08, 8'h0a);
    @(posedge ref_clk);
    #1;
    chk("cap_start", 16'h015f, {6'h00, cap_start_out});
    u_host.wr(8'h09, 8'h3c);
    rchk(8'h09, 8'h3c);
    chk("override", 16'h3c00, override_out);
    tdone("channel_copies");
    // Soft reset of channel one only
    u_host.wr(8'h41, 8'h12);
    u_host.wr(8'h03, 8'haa);
    u_host.wr(8'h00, 8'h00);
    rchk(8'h03, 8'haa);
    u_host.wr(8'h00, 8'h04);
    rchk(8'h00, 8'h00);
    rchk(8'h41, 8'h40);
    rchk(8'h03, 8'h00);
    rchk(8'h08, 8'h00);
    chk("override_rst", 16'h0000, override_out);
    u_host.wr(8'hff, 8'h04);
    rchk(8'h08, 8'h1f);
    rchk(8'h4f, 8'hf9);
    tdone("soft_reset");
    // Status and loss flags of channel zero
    {cdr_lock_in, lock_in, lock_fail_in, sig_detect_in} = 8'hff;
    repeat (8) @(posedge ref_clk);
    #1;
    rchk(8'h02, 8'h38);
    cdr_lock_in = 2'h2;
    sig_detect_in = 2'h2;
    repeat (8) @(posedge ref_clk);
    #1;
    rchk(8'h02, 8'h30);
    rchk(8'h01, 8'h11);
    rchk(8'h01, 8'h00);
    tdone("status_flags");
    summarize();
  end
endmodule : testbench
`default_nettype wire
